// ===== mspr_cfg.svh
`ifndef MSPR_CFG_SVH
`define MSPR_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MSPR_IDX_DRIVE          32'h0000_00E4
`define MSPR_IDX_PARAM          32'h0000_00E6
`define MSPR_IDX_EXTR           32'h0000_00E8
`define MSPR_IDX_CTRL           32'h0000_0100

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSPR_RESET_WORD         32'h0000_0000
`define MSPR_CTRL_RESET         1'b0
`define MSPR_READY_RESET        1'b1
`define MSPR_RESP_OKAY          1'b0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MSPR_MOD_IDX_LSB        16
`define MSPR_DUTY_LSB           4
`define MSPR_COPY_DONE_BIT      2
`define MSPR_RES_LSB            24
`define MSPR_KE_LSB             16
`define MSPR_IND_LSB            8
`define MSPR_R_ST_BIT           31
`define MSPR_L_ST_BIT           30
`define MSPR_KE_ST_BIT          29
`define MSPR_MECH_ST_BIT        28
`define MSPR_FREQ_LSB           24
`define MSPR_FREEZE_BIT         0

// reserved bits of each status word and of the control word, always zero
`define MSPR_DRIVE_RSVD_MASK    32'h0000_000B
`define MSPR_PARAM_RSVD_MASK    32'h0000_00FF
`define MSPR_EXTR_RSVD_MASK     32'h00FF_FFFF
`define MSPR_CTRL_RSVD_MASK     32'hFFFF_FFFE

// ----------------------------------------------------------------
// bus codes
// ----------------------------------------------------------------
`define MSPR_HTRANS_ACTIVE_BIT  1
`define MSPR_HSIZE_WORD         3'h2

`endif

// ===== mspr_pkg.sv
package mspr_pkg;

    typedef logic [31:0] mspr_word_t;

    // which word a read returns
    typedef enum logic [2:0] {
        MSPR_SEL_NONE,
        MSPR_SEL_DRIVE,
        MSPR_SEL_PARAM,
        MSPR_SEL_EXTR,
        MSPR_SEL_CTRL
    } mspr_sel_t;

    // live values from the control algorithm
    typedef struct packed {
        logic [15:0] mod_idx;
        logic [11:0] duty;
        logic        copy_done;
        logic [7:0]  res;
        logic [7:0]  ke;
        logic [7:0]  ind;
        logic        r_st;
        logic        l_st;
        logic        ke_st;
        logic        mech_st;
        logic [3:0]  freq;
    } mspr_sample_t;

    typedef struct packed {
        mspr_word_t drive;
        mspr_word_t param;
        mspr_word_t extr;
        mspr_word_t rd;
    } mspr_store_t;

    typedef struct packed {
        logic ready;
        logic resp;
        logic freeze;
        logic wr_pend;
    } mspr_top_t;

endpackage

// ===== mspr_if.sv
`timescale 1ns/10ps
`default_nettype none

// link between the bus front end and the status store
interface mspr_if;
    import mspr_pkg::*;

    mspr_sample_t sample;
    logic         freeze;
    logic         rd_en;
    mspr_sel_t    rd_sel;
    mspr_word_t   rd_data;

    modport ctl   (output sample, freeze, rd_en, rd_sel, input rd_data);
    modport store (input sample, freeze, rd_en, rd_sel, output rd_data);
endinterface

`default_nettype wire

// ===== mspr_status_store.sv
`timescale 1ns/10ps
`default_nettype none
`include "mspr_cfg.svh"

module mspr_status_store (
    input  wire logic clk,
    input  wire logic nrst,
    mspr_if.store     st
);
    import mspr_pkg::*;

    // ----------------------------------------------------------------
    // word packing
    // ----------------------------------------------------------------
    function automatic mspr_word_t pack_drive(input mspr_sample_t s);
        mspr_word_t w;
        w = `MSPR_RESET_WORD;
        w[`MSPR_MOD_IDX_LSB +: $bits(s.mod_idx)] = s.mod_idx;
        w[`MSPR_DUTY_LSB +: $bits(s.duty)]       = s.duty;
        w[`MSPR_COPY_DONE_BIT]                   = s.copy_done;
        return w;
    endfunction

    function automatic mspr_word_t pack_param(input mspr_sample_t s);
        mspr_word_t w;
        w = `MSPR_RESET_WORD;  // low byte stays zero
        w[`MSPR_RES_LSB +: $bits(s.res)] = s.res;
        w[`MSPR_KE_LSB +: $bits(s.ke)]   = s.ke;
        w[`MSPR_IND_LSB +: $bits(s.ind)] = s.ind;
        return w;
    endfunction

    function automatic mspr_word_t pack_extr(input mspr_sample_t s);
        mspr_word_t w;
        w = `MSPR_RESET_WORD;
        w[`MSPR_R_ST_BIT]    = s.r_st;
        w[`MSPR_L_ST_BIT]    = s.l_st;
        w[`MSPR_KE_ST_BIT]   = s.ke_st;
        w[`MSPR_MECH_ST_BIT] = s.mech_st;
        w[`MSPR_FREQ_LSB +: $bits(s.freq)] = s.freq;
        return w;
    endfunction

    mspr_store_t state_q;
    mspr_store_t state_d;
    mspr_word_t  ctrl_word;

    // ----------------------------------------------------------------
    // capture and read mux
    // ----------------------------------------------------------------
    // freeze holds all three words so software reads one coherent set
    always_comb begin
        state_d   = state_q;
        ctrl_word = `MSPR_RESET_WORD;
        ctrl_word[`MSPR_FREEZE_BIT] = st.freeze;
        if (!st.freeze) begin
            state_d.drive = pack_drive(st.sample);
            state_d.param = pack_param(st.sample);
            state_d.extr  = pack_extr(st.sample);
        end
        if (st.rd_en) begin
            case (st.rd_sel)
                MSPR_SEL_DRIVE: state_d.rd = state_q.drive;
                MSPR_SEL_PARAM: state_d.rd = state_q.param;
                MSPR_SEL_EXTR:  state_d.rd = state_q.extr;
                MSPR_SEL_CTRL:  state_d.rd = ctrl_word;
                default:        state_d.rd = `MSPR_RESET_WORD;
            endcase
        end
    end

    // every word starts at zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= {4{`MSPR_RESET_WORD}};
        end else begin
            state_q <= state_d;
        end
    end

    assign st.rd_data = state_q.rd;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // sampled nrst keeps the release edge out: the flops still reset there
    a_mod_idx_capture: assert property (
        nrst && !st.freeze |=>
            state_q.drive[`MSPR_MOD_IDX_LSB +: 16] == $past(st.sample.mod_idx))
        else $error("modulation index not captured");
    a_duty_capture: assert property (
        nrst && !st.freeze |=>
            state_q.drive[`MSPR_DUTY_LSB +: 12] == $past(st.sample.duty))
        else $error("duty command not captured");
    a_copy_done_flag: assert property (
        nrst && !st.freeze |=>
            state_q.drive[`MSPR_COPY_DONE_BIT] == $past(st.sample.copy_done))
        else $error("copy done flag wrong");
    a_param_fields: assert property (
        nrst && !st.freeze |=> state_q.param[31:8] ==
            $past({st.sample.res, st.sample.ke, st.sample.ind}))
        else $error("motor parameter fields wrong");
    a_extr_flags: assert property (
        nrst && !st.freeze |=> state_q.extr[31:24] == $past({st.sample.r_st, st.sample.l_st,
            st.sample.ke_st, st.sample.mech_st, st.sample.freq}))
        else $error("measurement status fields wrong");
    a_freeze_holds: assert property (
        st.freeze |=> $stable(state_q.drive) && $stable(state_q.param) && $stable(state_q.extr))
        else $error("status changed while frozen");
endmodule

`default_nettype wire

// ===== mspr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mspr_cfg.svh"

module mspr_top (
    input  wire logic                clk,
    input  wire logic                nrst,
    // ahb-lite slave port
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire mspr_pkg::mspr_word_t hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output mspr_pkg::mspr_word_t     hrdata,
    // live values from the control algorithm
    input  wire logic [15:0]         applied_modulation_index,
    input  wire logic [11:0]         duty_command,
    input  wire logic                config_copy_done,
    input  wire logic [7:0]          measured_winding_resistance,
    input  wire logic [7:0]          measured_back_emf_constant,
    input  wire logic [7:0]          measured_inductance,
    input  wire logic                resistance_measure_state,
    input  wire logic                inductance_measure_state,
    input  wire logic                emf_constant_measure_state,
    input  wire logic                mechanical_measure_state,
    input  wire logic [3:0]          recommended_switching_frequency
);
    import mspr_pkg::*;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // indices are not all word aligned, so the bus sees them times four
    function automatic mspr_word_t byte_addr(input mspr_word_t idx);
        return idx << 2;
    endfunction

    function automatic mspr_sel_t decode(input mspr_word_t a);
        mspr_sel_t s;
        s = MSPR_SEL_NONE;
        if (a == byte_addr(`MSPR_IDX_DRIVE)) begin
            s = MSPR_SEL_DRIVE;
        end else if (a == byte_addr(`MSPR_IDX_PARAM)) begin
            s = MSPR_SEL_PARAM;
        end else if (a == byte_addr(`MSPR_IDX_EXTR)) begin
            s = MSPR_SEL_EXTR;
        end else if (a == byte_addr(`MSPR_IDX_CTRL)) begin
            s = MSPR_SEL_CTRL;
        end
        return s;
    endfunction

    mspr_if     ifc ();
    mspr_top_t  st_q;
    mspr_top_t  st_d;
    logic       req;
    logic       acc;
    mspr_sel_t  sel;

    // a transfer is taken only on a whole-word access; other sizes
    // see a zero word and change nothing
    assign req = hsel & hready & htrans[`MSPR_HTRANS_ACTIVE_BIT];
    assign acc = req & (hsize == `MSPR_HSIZE_WORD);
    assign sel = decode(haddr);

    // ----------------------------------------------------------------
    // bus state
    // ----------------------------------------------------------------
    // zero wait states, so ready and resp never move after reset
    always_comb begin
        st_d       = st_q;
        st_d.ready = `MSPR_READY_RESET;
        st_d.resp  = `MSPR_RESP_OKAY;
        // write data arrives in the data phase after the address
        if (st_q.wr_pend) begin
            st_d.freeze = hwdata[`MSPR_FREEZE_BIT];
        end
        // only the control word accepts data; status writes fall away
        st_d.wr_pend = acc & hwrite & (sel == MSPR_SEL_CTRL);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q.ready   <= `MSPR_READY_RESET;
            st_q.resp    <= `MSPR_RESP_OKAY;
            st_q.freeze  <= `MSPR_CTRL_RESET;
            st_q.wr_pend <= `MSPR_CTRL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // store hookup
    // ----------------------------------------------------------------
    // next freeze value is forwarded so a read right after a write
    // of the control word already sees the new setting
    assign ifc.freeze             = st_d.freeze;
    // any request reloads the read register, so a sub-word one reads zero
    assign ifc.rd_en              = req;
    assign ifc.rd_sel             = (hwrite | !acc) ? MSPR_SEL_NONE : sel;
    assign ifc.sample.mod_idx     = applied_modulation_index;
    assign ifc.sample.duty        = duty_command;
    assign ifc.sample.copy_done   = config_copy_done;
    assign ifc.sample.res         = measured_winding_resistance;
    assign ifc.sample.ke          = measured_back_emf_constant;
    assign ifc.sample.ind         = measured_inductance;
    assign ifc.sample.r_st        = resistance_measure_state;
    assign ifc.sample.l_st        = inductance_measure_state;
    assign ifc.sample.ke_st       = emf_constant_measure_state;
    assign ifc.sample.mech_st     = mechanical_measure_state;
    assign ifc.sample.freq        = recommended_switching_frequency;

    mspr_status_store u_store (
        .clk  (clk),
        .nrst (nrst),
        .st   (ifc.store)
    );

    // outputs straight from flops
    assign hreadyout = st_q.ready;
    assign hresp     = st_q.resp;
    assign hrdata    = ifc.rd_data;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_read(mspr_sel_t which);
        acc && !hwrite && (sel == which);
    endsequence

    sequence s_ctrl_write;
        (acc && hwrite && (sel == MSPR_SEL_CTRL)) ##1 1'b1;
    endsequence

    a_bus_okay: assert property (
        hreadyout && (hresp == `MSPR_RESP_OKAY))
        else $error("slave not ready or not okay");

    a_unmapped_zero: assert property (
        s_read(MSPR_SEL_NONE) |=> (hrdata == `MSPR_RESET_WORD))
        else $error("unmapped read not zero");

    a_drive_rsvd_zero: assert property (
        s_read(MSPR_SEL_DRIVE) |=> ((hrdata & `MSPR_DRIVE_RSVD_MASK) == `MSPR_RESET_WORD))
        else $error("drive status reserved bits set");

    a_param_rsvd_zero: assert property (
        s_read(MSPR_SEL_PARAM) |=> ((hrdata & `MSPR_PARAM_RSVD_MASK) == `MSPR_RESET_WORD))
        else $error("parameter word low byte set");

    a_extr_rsvd_zero: assert property (
        s_read(MSPR_SEL_EXTR) |=> ((hrdata & `MSPR_EXTR_RSVD_MASK) == `MSPR_RESET_WORD))
        else $error("measurement status reserved bits set");

    a_status_write_void: assert property (
        (acc && hwrite && (sel != MSPR_SEL_CTRL)) |=> !st_q.wr_pend)
        else $error("status write was accepted");

    a_ctrl_write_lands: assert property (
        s_ctrl_write |=> (st_q.freeze == $past(hwdata[`MSPR_FREEZE_BIT])))
        else $error("control write not applied");

    a_ctrl_readback: assert property (
        s_read(MSPR_SEL_CTRL) |=> (hrdata[`MSPR_FREEZE_BIT] == $past(st_d.freeze)))
        else $error("control readback wrong");

    a_write_no_data: assert property (
        (acc && hwrite) |=> (hrdata == `MSPR_RESET_WORD))
        else $error("write phase returned data");

    // ----------------------------------------------------------------
    // field checks against the live inputs
    // ----------------------------------------------------------------
    // a word read at edge n was loaded at n-1 from inputs seen there,
    // so a read only counts when freeze was low one edge earlier
    sequence s_live_read(mspr_sel_t which);
        !ifc.freeze ##1 s_read(which);
    endsequence

    a_live_mod_idx: assert property (
        s_live_read(MSPR_SEL_DRIVE) |=>
            (hrdata[`MSPR_MOD_IDX_LSB +: $bits(applied_modulation_index)] ==
             $past(applied_modulation_index, 2)))
        else $error("modulation index read wrong");

    a_live_duty: assert property (
        s_live_read(MSPR_SEL_DRIVE) |=>
            (hrdata[`MSPR_DUTY_LSB +: $bits(duty_command)] ==
             $past(duty_command, 2)))
        else $error("duty command read wrong");

    a_live_copy_done: assert property (
        s_live_read(MSPR_SEL_DRIVE) |=>
            (hrdata[`MSPR_COPY_DONE_BIT] ==
             $past(config_copy_done, 2)))
        else $error("copy done flag read wrong");

    a_live_resistance: assert property (
        s_live_read(MSPR_SEL_PARAM) |=>
            (hrdata[`MSPR_RES_LSB +: $bits(measured_winding_resistance)] ==
             $past(measured_winding_resistance, 2)))
        else $error("winding resistance read wrong");

    a_live_emf_const: assert property (
        s_live_read(MSPR_SEL_PARAM) |=>
            (hrdata[`MSPR_KE_LSB +: $bits(measured_back_emf_constant)] ==
             $past(measured_back_emf_constant, 2)))
        else $error("back-emf constant read wrong");

    a_live_inductance: assert property (
        s_live_read(MSPR_SEL_PARAM) |=>
            (hrdata[`MSPR_IND_LSB +: $bits(measured_inductance)] ==
             $past(measured_inductance, 2)))
        else $error("inductance read wrong");

    a_live_res_state: assert property (
        s_live_read(MSPR_SEL_EXTR) |=>
            (hrdata[`MSPR_R_ST_BIT] ==
             $past(resistance_measure_state, 2)))
        else $error("resistance state read wrong");

    a_live_ind_state: assert property (
        s_live_read(MSPR_SEL_EXTR) |=>
            (hrdata[`MSPR_L_ST_BIT] ==
             $past(inductance_measure_state, 2)))
        else $error("inductance state read wrong");

    a_live_emf_state: assert property (
        s_live_read(MSPR_SEL_EXTR) |=>
            (hrdata[`MSPR_KE_ST_BIT] ==
             $past(emf_constant_measure_state, 2)))
        else $error("emf constant state read wrong");

    a_live_mech_state: assert property (
        s_live_read(MSPR_SEL_EXTR) |=>
            (hrdata[`MSPR_MECH_ST_BIT] ==
             $past(mechanical_measure_state, 2)))
        else $error("mechanical state read wrong");

    a_live_freq_code: assert property (
        s_live_read(MSPR_SEL_EXTR) |=>
            (hrdata[`MSPR_FREQ_LSB +: $bits(recommended_switching_frequency)] ==
             $past(recommended_switching_frequency, 2)))
        else $error("frequency code read wrong");

    // ----------------------------------------------------------------
    // bus and control checks
    // ----------------------------------------------------------------
    // read data must stand until the next request replaces it
    a_rdata_stands: assert property (
        !req |=> $stable(hrdata))
        else $error("read data moved without a request");

    a_subword_read_zero: assert property (
        (req && !acc) |=> (hrdata == `MSPR_RESET_WORD))
        else $error("sub-word access returned data");

    a_subword_write_void: assert property (
        (req && !acc && hwrite) |=> !st_q.wr_pend)
        else $error("sub-word write was accepted");

    // freeze only moves in the data phase of a control write
    a_freeze_write_only: assert property (
        !st_q.wr_pend |=> $stable(st_q.freeze))
        else $error("freeze moved without a write");

    a_ctrl_rsvd_zero: assert property (
        s_read(MSPR_SEL_CTRL) |=> ((hrdata & `MSPR_CTRL_RSVD_MASK) == `MSPR_RESET_WORD))
        else $error("control word reserved bits set");
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "mspr_cfg.svh"

module testbench;
    import mspr_pkg::*;

    // ----------------------------------------------------------------
    // signals and addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] A_DRIVE = `MSPR_IDX_DRIVE * 4;
    localparam logic [31:0] A_PARAM = `MSPR_IDX_PARAM * 4;
    localparam logic [31:0] A_EXTR  = `MSPR_IDX_EXTR * 4;
    localparam logic [31:0] A_CTRL  = `MSPR_IDX_CTRL * 4;
    localparam logic [31:0] A_HOLE  = A_DRIVE + 32'h0000_0004;

    logic        clk, nrst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    mspr_word_t  hwdata, hrdata;
    logic [15:0] mi;
    logic [11:0] du;
    logic        cd;
    logic [7:0]  rs, ke, ind;
    logic [3:0]  st, fq;
    int          miscompares, tests_run, cycles;

    mspr_top dut (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .applied_modulation_index(mi), .duty_command(du), .config_copy_done(cd),
        .measured_winding_resistance(rs), .measured_back_emf_constant(ke),
        .measured_inductance(ind), .resistance_measure_state(st[3]),
        .inductance_measure_state(st[2]), .emf_constant_measure_state(st[1]),
        .mechanical_measure_state(st[0]), .recommended_switching_frequency(fq)
    );

    // clock and cycle ceiling; a hung handshake ends the run here
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_sim();
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input mspr_word_t seen, input mspr_word_t exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one single ahb transfer; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] addr, input mspr_word_t wd,
                       output mspr_word_t rd);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
    endtask

    // expected words built from the live inputs
    function automatic mspr_word_t exp_drive();
        return {mi, du, 1'b0, cd, 2'b00};
    endfunction
    function automatic mspr_word_t exp_param();
        return {rs, ke, ind, 8'h00};
    endfunction
    function automatic mspr_word_t exp_extr();
        return {st, fq, 24'h00_0000};
    endfunction

    // two edges so the one-cycle sampling lag has passed
    task automatic set_in(input logic [15:0] a, input logic [11:0] b, input logic c,
                          input logic [7:0] r, input logic [7:0] k, input logic [7:0] l,
                          input logic [3:0] s, input logic [3:0] f);
        mi <= a; du <= b; cd <= c; rs <= r; ke <= k; ind <= l; st <= s; fq <= f;
        repeat (2) @(posedge clk);
    endtask

    task automatic read_all();
        mspr_word_t d;
        bus(1'b0, A_DRIVE, 32'h0000_0000, d);
        check("drive_state_status", d, exp_drive());
        bus(1'b0, A_PARAM, 32'h0000_0000, d);
        check("motor_parameter_results", d, exp_param());
        bus(1'b0, A_EXTR, 32'h0000_0000, d);
        check("extraction_progress_status", d, exp_extr());
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // live inputs are nonzero, yet the read path must show zero in reset
    // looked at just after the edge: the reset may only land on that edge
    task automatic t_reset();
        @(posedge clk);
        #1;
        check("hrdata in reset", hrdata, 32'h0000_0000);
        check("hreadyout in reset", {31'h0, hreadyout}, 32'h0000_0001);
    endtask

    // all-ones shows reserved bits stay low; odd patterns catch swapped fields
    task automatic t_fields();
        set_in(16'hFFFF, 12'hFFF, 1'b1, 8'hFF, 8'hFF, 8'hFF, 4'hF, 4'hF);
        read_all();
        set_in(16'h8001, 12'h801, 1'b0, 8'h81, 8'h42, 8'h24, 4'hA, 4'h9);
        read_all();
        set_in(16'h0000, 12'h000, 1'b1, 8'h00, 8'h00, 8'h00, 4'h5, 4'h6);
        read_all();
    endtask

    // writes of the inverted word must not reach any status word; frozen,
    // so live sampling cannot hide a write that landed
    task automatic t_write_ignored();
        mspr_word_t d;
        set_in(16'h1234, 12'h567, 1'b1, 8'h9A, 8'hBC, 8'hDE, 4'h3, 4'hC);
        bus(1'b1, A_CTRL, 32'h0000_0001, d);
        bus(1'b1, A_DRIVE, ~exp_drive(), d);
        bus(1'b1, A_PARAM, ~exp_param(), d);
        bus(1'b1, A_EXTR, ~exp_extr(), d);
        read_all();
        bus(1'b1, A_CTRL, 32'h0000_0000, d);
        // reserved offsets are only read, never written
        bus(1'b0, A_HOLE, 32'h0000_0000, d);
        check("unmapped read", d, 32'h0000_0000);
    endtask

    // sub-word accesses are not taken: reads give zero, writes drop
    task automatic t_subword();
        mspr_word_t d;
        hsize <= 3'h0;
        bus(1'b0, A_DRIVE, 32'h0000_0000, d);
        check("byte read", d, 32'h0000_0000);
        bus(1'b1, A_CTRL, 32'h0000_0001, d);
        hsize <= `MSPR_HSIZE_WORD;
        bus(1'b0, A_CTRL, 32'h0000_0000, d);
        check("control after byte write", d, 32'h0000_0000);
    endtask

    // the frozen drive word holds its old value, then all words follow the inputs again
    task automatic t_freeze();
        mspr_word_t d, old;
        old = exp_drive();
        bus(1'b1, A_CTRL, 32'h0000_0001, d);
        set_in(16'h4321, 12'hABC, 1'b0, 8'h11, 8'h22, 8'h33, 4'h6, 4'h1);
        bus(1'b0, A_DRIVE, 32'h0000_0000, d);
        check("frozen drive word", d, old);
        bus(1'b0, A_CTRL, 32'h0000_0000, d);
        check("control word", d, 32'h0000_0001);
        bus(1'b1, A_CTRL, 32'h0000_0000, d);
        repeat (2) @(posedge clk);
        read_all();
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0; nrst = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
        hwrite = 1'b0; hsize = `MSPR_HSIZE_WORD; hwdata = 32'h0000_0000;
        mi = 16'hA5A5; du = 12'h5A5; cd = 1'b1; rs = 8'h5A; ke = 8'hA5; ind = 8'h3C;
        st = 4'hF; fq = 4'h7;
        miscompares = 0; tests_run = 0; cycles = 0;
        t_reset();
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_fields();
        t_write_ignored();
        t_freeze();
        t_subword();
        end_sim();
    end
endmodule

`default_nettype wire
